// ### rtl/ext_bus_pkg.sv
/*
  constants for the external data bus sequencer: widths, reset values, timing.
  assumes a single clock domain, the pll clock at 12.58 MHz.
*/
package ext_bus_pkg;
  localparam int          ADDR_WIDTH       = 24;
  localparam int          DATA_WIDTH       = 8;
  localparam int          WAIT_WIDTH       = 8;
  localparam int          DIV_WIDTH        = 3;
  localparam logic [7:0]  PORT_RESET       = 8'hFF;
  localparam logic [7:0]  WAIT_RESET       = 8'h00;
  localparam int          STROBE_DIS_BIT   = 4;
  localparam int          PLL_FREQ_KHZ     = 12_580;
  localparam logic [2:0]  DIV_UNDIVIDED    = 3'h0;
  localparam int          SETUP_CYCLES     = 1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DATA,
    ST_WAIT,
    ST_LAST
  } bus_state_type;
endpackage : ext_bus_pkg

// ### rtl/external_data_bus_ale.sv
/*
  external data bus sequencer of a single-cycle core: strobe generation,
  multiplexed low address/data byte, wait stretching, core clock divider
  and machine-cycle tick.
  assumes the core presents one instruction at a time on instr_start_i,
  holding it until instr_done_o, and that the port pins come in unsynchronised.
  a read ends two clocks after its last tick, while the byte crosses the synchroniser.
*/
// Function
// - single-cycle instruction keeps the address strobe high for its whole cycle
// - multi-cycle instruction: strobe high first cycle, low for the rest
// - no external fetches; data space addressed with 24 bits, 16 MB
// - each external data move of 2 or more cycles is stretched by the programmed wait count; shorter moves get count data cycles, at least 1
// - low byte port carries low address byte then data byte
// - in bus use the port drives ones actively high
// - outside bus use the port is open drain, written ones float
// - one machine cycle equals one core clock; timer tick per core clock
// - most instructions finish in one or two core clocks
// - core clock comes from the pll clock through a programmable divider
// - strobe latches low address and page bytes; power control bit 4 disables it
// - program store strobe stays high during internal execution
`timescale 1ns/1ps
`default_nettype none
module external_data_bus_ale #(
  parameter int ADDR_WIDTH = ext_bus_pkg::ADDR_WIDTH,
  parameter int WAIT_WIDTH = ext_bus_pkg::WAIT_WIDTH
) (
  input  wire logic                  ref_clk_i,
  input  wire logic                  reset_i,
  input  wire logic                  instr_start_i,
  input  wire logic [3:0]            instr_cycles_i,
  input  wire logic                  instr_is_move_i,
  input  wire logic                  move_write_i,
  input  wire logic [ADDR_WIDTH-1:0] move_addr_i,
  input  wire logic [7:0]            move_wdata_i,
  input  wire logic [WAIT_WIDTH-1:0] external_wait_count_i,
  input  wire logic [7:0]            power_control_reg_i,
  input  wire logic [2:0]            clock_divider_control_i,
  input  wire logic [7:0]            port_latch_i,
  input  wire logic [7:0]            low_byte_port_i,
  output logic                       instr_done_o,
  output logic [7:0]                 move_rdata_o,
  output logic                       move_rdata_valid_o,
  output logic                       addr_strobe_o,
  output logic                       program_store_strobe_o,
  output logic [7:0]                 low_byte_port_o,
  output logic [7:0]                 low_byte_port_oe_o,
  output logic [15:0]                high_addr_o,
  output logic                       read_strobe_n_o,
  output logic                       write_strobe_n_o,
  output logic                       core_clk_en_o,
  output logic                       timer_tick_o
);

  // clock divider: core cycle advances once every 2^div pll cycles
  // the divided clock is an enable pulse, so every register still sees
  // every pll edge and no second clock domain appears
  logic [6:0] div_cnt;
  logic [6:0] next_div_cnt;
  logic       tick;
  logic       next_tick;

  function automatic logic [6:0] div_limit(input logic [2:0] sel);
    div_limit = 7'((7'h01 << sel) - 7'h01);
  endfunction : div_limit

  always_comb begin
    next_div_cnt = div_cnt + 7'h01;
    next_tick    = 1'b0;
    if (div_cnt >= div_limit(clock_divider_control_i)) begin
      next_div_cnt = '0;
      next_tick    = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      div_cnt <= '0;
      tick    <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      tick    <= next_tick;
    end
  end

  // pin input synchroniser; first stage only feeds the second
  // read data therefore lags the pins by two clocks
  logic [7:0] port_meta;
  logic [7:0] port_sync;

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      port_meta <= ext_bus_pkg::PORT_RESET;
      port_sync <= ext_bus_pkg::PORT_RESET;
    end else begin
      port_meta <= low_byte_port_i;
      port_sync <= port_meta;
    end
  end

  // instruction / bus sequencer, advancing once per machine cycle
  ext_bus_pkg::bus_state_type state;
  ext_bus_pkg::bus_state_type next_state;
  // four spare bits hold the cycle count plus the wait count without wrapping
  logic [WAIT_WIDTH+3:0]      remain;
  logic [WAIT_WIDTH+3:0]      next_remain;
  logic                       is_move;
  logic                       next_is_move;
  logic                       is_write;
  logic                       next_is_write;
  logic [ADDR_WIDTH-1:0]      addr;
  logic [ADDR_WIDTH-1:0]      next_addr;
  logic [7:0]                 wdata;
  logic [7:0]                 next_wdata;
  logic                       strobe;
  logic                       next_strobe;
  logic                       done;
  logic                       next_done;
  logic [7:0]                 rdata;
  logic [7:0]                 next_rdata;
  logic                       rvalid;
  logic                       next_rvalid;
  logic                       rd_n;
  logic                       next_rd_n;
  logic                       wr_n;
  logic                       next_wr_n;
  logic [7:0]                 port_out;
  logic [7:0]                 next_port_out;
  logic [7:0]                 port_oe;
  logic [7:0]                 next_port_oe;
  logic [15:0]                haddr;
  logic [15:0]                next_haddr;
  logic [1:0]                 settle;
  logic [1:0]                 next_settle;

  // open-drain: a zero pulls low, a one floats
  // bus cycles override this with actively driven ones
  function automatic logic [7:0] od_enable(input logic [7:0] val);
    od_enable = ~val;
  endfunction : od_enable

  always_comb begin
    next_state    = state;
    next_remain   = remain;
    next_is_move  = is_move;
    next_is_write = is_write;
    next_addr     = addr;
    next_wdata    = wdata;
    next_strobe   = 1'b0;
    next_done     = 1'b0;
    next_rdata    = rdata;
    next_rvalid   = 1'b0;
    next_rd_n     = 1'b1;
    next_wr_n     = 1'b1;
    next_haddr    = haddr;
    next_port_out = port_latch_i;
    next_port_oe  = od_enable(port_latch_i);
    next_settle   = 2'h0;
    // a read byte needs two more clocks to cross the pin synchroniser;
    // reading the synchroniser at the last tick would return a stale byte
    if (settle != 2'h0) begin
      next_settle = settle - 2'h1;
      if (settle == 2'h1) begin
        next_rdata  = port_sync;
        next_rvalid = 1'b1;
        next_done   = 1'b1;
        next_state  = ext_bus_pkg::ST_IDLE;
      end
    end else if (tick) begin
      case (state)
        ext_bus_pkg::ST_IDLE: begin
          if (instr_start_i) begin
            next_is_move  = instr_is_move_i;
            next_is_write = move_write_i;
            next_addr     = move_addr_i;
            next_wdata    = move_wdata_i;
            // extra cycles beyond the first: given count less one, plus waits for moves
            next_remain   = (WAIT_WIDTH + 4)'(instr_cycles_i == 4'h0 ? 4'h0
                                              : instr_cycles_i - 4'h1);
            if (instr_is_move_i) begin
              next_remain = next_remain
                          + (WAIT_WIDTH + 4)'(external_wait_count_i);
            end
            // strobe high in the first machine cycle of every instruction
            next_strobe = ~power_control_reg_i[ext_bus_pkg::STROBE_DIS_BIT];
            if (instr_is_move_i) begin
              next_haddr    = 16'(move_addr_i[ADDR_WIDTH-1:8]);
              next_port_out = move_addr_i[7:0];
              next_port_oe  = 8'hFF;
              next_state    = ext_bus_pkg::ST_ADDR;
            end else if (next_remain == '0) begin
              // single machine cycle: finish at its closing tick, strobe high until then
              next_state = ext_bus_pkg::ST_LAST;
            end else begin
              next_state = ext_bus_pkg::ST_WAIT;
            end
          end
        end
        ext_bus_pkg::ST_ADDR, ext_bus_pkg::ST_WAIT, ext_bus_pkg::ST_DATA: begin
          // later cycles keep the strobe low
          if (is_move) begin
            next_port_out = is_write ? wdata : 8'hFF;
            next_port_oe  = is_write ? 8'hFF : 8'h00;
            next_rd_n     = is_write;
            next_wr_n     = ~is_write;
          end
          if (remain <= (WAIT_WIDTH + 4)'(1)) begin
            next_remain = '0;
            next_state  = ext_bus_pkg::ST_LAST;
          end else begin
            next_remain = remain - (WAIT_WIDTH + 4)'(1);
            next_state  = ext_bus_pkg::ST_DATA;
          end
        end
        ext_bus_pkg::ST_LAST: begin
          if (is_move && !is_write) begin
            // first stage takes the pins at this tick, as the read strobe rises;
            // the ram must hold its byte until that rising edge
            next_settle = 2'h2;
          end else begin
            next_done  = 1'b1;
            next_state = ext_bus_pkg::ST_IDLE;
          end
        end
        default: begin
          next_state = ext_bus_pkg::ST_IDLE;
        end
      endcase
    end else begin
      // hold the strobes between machine cycles; the port is held only during a move, otherwise it follows port_latch_i
      next_strobe   = strobe;
      next_rd_n     = rd_n;
      next_wr_n     = wr_n;
      if (state != ext_bus_pkg::ST_IDLE && is_move) begin
        next_port_out = port_out;
        next_port_oe  = port_oe;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      state    <= ext_bus_pkg::ST_IDLE;
      remain   <= '0;
      is_move  <= 1'b0;
      is_write <= 1'b0;
      addr     <= '0;
      wdata    <= '0;
      strobe   <= 1'b0;
      done     <= 1'b0;
      rdata    <= '0;
      rvalid   <= 1'b0;
      rd_n     <= 1'b1;
      wr_n     <= 1'b1;
      port_out <= ext_bus_pkg::PORT_RESET;
      port_oe  <= 8'h00;
      haddr    <= '0;
      settle   <= 2'h0;
    end else begin
      state    <= next_state;
      remain   <= next_remain;
      is_move  <= next_is_move;
      is_write <= next_is_write;
      addr     <= next_addr;
      wdata    <= next_wdata;
      strobe   <= next_strobe;
      done     <= next_done;
      rdata    <= next_rdata;
      rvalid   <= next_rvalid;
      rd_n     <= next_rd_n;
      wr_n     <= next_wr_n;
      port_out <= next_port_out;
      port_oe  <= next_port_oe;
      haddr    <= next_haddr;
      settle   <= next_settle;
    end
  end

  // no external program store: strobe idles high
  // no reset needed: it is high from the first clock and nothing reads it back
  logic pstore;
  always_ff @(posedge ref_clk_i) begin
    pstore <= 1'b1;
  end

  assign instr_done_o           = done;
  assign move_rdata_o           = rdata;
  assign move_rdata_valid_o     = rvalid;
  assign addr_strobe_o          = strobe;
  assign program_store_strobe_o = pstore;
  assign low_byte_port_o        = port_out;
  assign low_byte_port_oe_o     = port_oe;
  assign high_addr_o            = haddr;
  assign read_strobe_n_o        = rd_n;
  assign write_strobe_n_o       = wr_n;
  assign core_clk_en_o          = tick;
  assign timer_tick_o           = tick;

endmodule : external_data_bus_ale
`default_nettype wire

// ### verification/ext_ram_model.sv
/* ram behind an address latch on the multiplexed port.
   assumes the bench resolves the pin wire with a pull-up. */
`timescale 1ns/1ps
`default_nettype none
module ext_ram_model (
  input  wire logic        addr_strobe_i,
  input  wire logic [15:0] high_addr_i,
  input  wire logic [7:0]  port_i,
  input  wire logic        read_strobe_n_i,
  input  wire logic        write_strobe_n_i,
  output logic      [7:0]  data_o,
  output logic             drive_o
);
  logic [7:0]  mem [int];
  logic [23:0] addr = 24'h00_0000;
  logic [7:0]  wbuf = 8'h00;
  // look 1 ns late so a strobe edge never races the byte it qualifies
  always @(addr_strobe_i, port_i) #1 if (addr_strobe_i) addr = {high_addr_i, port_i};
  always @(port_i, write_strobe_n_i) #1 if (!write_strobe_n_i) wbuf = port_i;
  always @(posedge write_strobe_n_i) mem[addr] = wbuf;
  always @(addr, read_strobe_n_i) data_o = mem.exists(addr) ? mem[addr] : addr[7:0] ^ addr[23:16];
  assign drive_o = !read_strobe_n_i;
endmodule : ext_ram_model
`default_nettype wire

// ### verification/external_data_bus_ale_asserts.sv
/* port checks of the external bus sequencer.
   assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module external_data_bus_ale_asserts (
  input wire logic        ref_clk_i,
  input wire logic        reset_i,
  input wire logic        instr_start_i,
  input wire logic [3:0]  instr_cycles_i,
  input wire logic        instr_is_move_i,
  input wire logic        move_write_i,
  input wire logic [23:0] move_addr_i,
  input wire logic [7:0]  power_control_reg_i,
  input wire logic [2:0]  clock_divider_control_i,
  input wire logic [7:0]  port_latch_i,
  input wire logic        instr_done_o,
  input wire logic        addr_strobe_o,
  input wire logic        program_store_strobe_o,
  input wire logic [7:0]  low_byte_port_o,
  input wire logic [7:0]  low_byte_port_oe_o,
  input wire logic [15:0] high_addr_o,
  input wire logic        read_strobe_n_o,
  input wire logic        write_strobe_n_o,
  input wire logic        core_clk_en_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  logic busy, next_busy, taken, div0, fast;
  // mirrors the idle state so acceptance is visible at the ports
  assign taken = instr_start_i && core_clk_en_o && !busy;
  assign div0  = clock_divider_control_i == 3'h0;
  assign fast  = div0 && !power_control_reg_i[4];
  always_comb next_busy = taken || (busy && !instr_done_o);
  always_ff @(posedge ref_clk_i) busy <= !reset_i && next_busy;
  sequence addr_phase;
    addr_strobe_o && low_byte_port_o == move_addr_i[7:0] && low_byte_port_oe_o == 8'hFF
      && high_addr_o == move_addr_i[23:8];
  endsequence
  sequence data_phase;
    !addr_strobe_o && (move_write_i ? !write_strobe_n_o && low_byte_port_oe_o == 8'hFF
      : !read_strobe_n_o && low_byte_port_oe_o == 8'h00);
  endsequence
  strobe_seq_a:
    assert property (taken && fast |=> addr_strobe_o ##1
      (!addr_strobe_o || instr_cycles_i < 4'h2 && !instr_is_move_i)) else $error("bad strobe");
  move_phases_a:
    assert property (taken && fast && instr_is_move_i |=> addr_phase ##1 data_phase)
    else $error("bad move phases");
  strobe_width_a:
    assert property ($rose(addr_strobe_o) && clock_divider_control_i == 3'h1 |=> addr_strobe_o)
    else $error("short strobe");
  strobe_off_a:
    assert property (power_control_reg_i[4] && $past(power_control_reg_i[4]) |-> !addr_strobe_o)
    else $error("strobe not disabled");
  store_high_a:
    assert property (!$past(reset_i) |-> program_store_strobe_o) else $error("store strobe low");
  port_idle_a:
    assert property (!busy && !$past(busy) && $stable(port_latch_i) |-> low_byte_port_oe_o
      == ~port_latch_i && (low_byte_port_o & ~port_latch_i) == 8'h00) else $error("bad idle port");
  tick_every_a:
    assert property (!$past(reset_i) && $past(div0) |-> core_clk_en_o) else $error("tick missing");
  tick_gap_a:
    assert property (core_clk_en_o && clock_divider_control_i == 3'h1
      && $stable(clock_divider_control_i) |=> !core_clk_en_o) else $error("tick too often");
endmodule : external_data_bus_ale_asserts
bind external_data_bus_ale external_data_bus_ale_asserts chk_u (.*);
`default_nettype wire

// ### verification/external_data_bus_ale_tb.sv
/* self-checking bench of the external bus sequencer with a ram on the port.
   assumes the ram model and the bound checker are compiled alongside. */
`timescale 1ns/1ps
`default_nettype none
module external_data_bus_ale_tb;
  logic        ref_clk_i = 1'b0, reset_i = 1'b1, instr_start_i = 1'b0, ram_drive;
  logic        instr_is_move_i = 1'b0, move_write_i = 1'b0, instr_done_o, core_clk_en_o;
  logic        move_rdata_valid_o, addr_strobe_o, program_store_strobe_o, timer_tick_o;
  logic        read_strobe_n_o, write_strobe_n_o;
  logic [3:0]  instr_cycles_i = 4'h1;
  logic [2:0]  clock_divider_control_i = 3'h0;
  logic [23:0] move_addr_i = 24'h00_0000;
  logic [15:0] high_addr_o;
  logic [7:0]  move_wdata_i = 8'h00, external_wait_count_i = 8'h00, power_control_reg_i = 8'h00;
  logic [7:0]  port_latch_i = 8'hFF, low_byte_port_i, ram_data, move_rdata_o;
  logic [7:0]  low_byte_port_o, low_byte_port_oe_o;
  logic [7:0]  shadow [int];
  int          fail_count = 0, n_checks = 0, seed = 32'h8a12_c559, k, n, t;
  // bits nobody drives are pulled up outside the chip
  assign low_byte_port_i = low_byte_port_oe_o & low_byte_port_o
                           | ~low_byte_port_oe_o & (ram_drive ? ram_data : 8'hFF);
  external_data_bus_ale dut_u (.*);
  ext_ram_model ram_u (.addr_strobe_i(addr_strobe_o), .high_addr_i(high_addr_o),
    .port_i(low_byte_port_i), .read_strobe_n_i(read_strobe_n_o),
    .write_strobe_n_i(write_strobe_n_o), .data_o(ram_data), .drive_o(ram_drive));
  always #5 ref_clk_i = ~ref_clk_i;
  function automatic logic [7:0] exp_lat(logic [3:0] c, logic mv, wr, logic [7:0] w);
    logic [7:0] m;
    m = (c == 4'h0) ? 8'h00 : {4'h0, c} - 8'h01;
    if (!mv) return m + 8'h01;
    // address cycle, then data cycles; reads add two synchroniser clocks
    return (wr ? 8'h01 : 8'h03) + ((m + w == 8'h00) ? 8'h01 : m + w);
  endfunction : exp_lat
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic results();
    if (fail_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results
  task automatic run(logic [3:0] c, logic mv, wr, logic [23:0] a, logic [7:0] w, wd);
    logic [7:0] er;
    er = shadow.exists(a) ? shadow[a] : a[7:0] ^ a[23:16];
    @(posedge ref_clk_i);
    #1 {instr_cycles_i, instr_is_move_i, move_write_i, move_addr_i} = {c, mv, wr, a};
    {external_wait_count_i, move_wdata_i, instr_start_i} = {w, wd, 1'b1};
    if (mv && wr) shadow[a] = wd;
    k = -1;
    do begin
      @(posedge ref_clk_i);
      #1 k++;
    end while (instr_done_o !== 1'b1 && k < 400);
    instr_start_i = 1'b0;
    check("done", 8'h01, {7'h00, instr_done_o});
    if (instr_done_o !== 1'b1) results();
    if (clock_divider_control_i == 3'h0) check("cycles", exp_lat(c, mv, wr, w), 8'(k));
    if (mv && !wr) check("rvalid", 8'h01, {7'h00, move_rdata_valid_o});
    if (mv && !wr) check("rdata", er, move_rdata_o);
  endtask : run
  initial begin
    repeat (2) @(posedge ref_clk_i);
    #1 reset_i = 1'b0;
    for (int d = 3; d >= 0; d--) begin
      clock_divider_control_i = 3'(d);
      repeat (8) @(posedge ref_clk_i);
      {n, t} = '0;
      repeat (64) begin
        @(posedge ref_clk_i);
        #1 n += core_clk_en_o;
        t += timer_tick_o;
      end
      check("core ticks", 8'(64 >> d), 8'(n));
      check("timer ticks", 8'(64 >> d), 8'(t));
    end
    for (int c = 0; c < 16; c++) run(4'(c), 1'b0, 1'b0, 24'h00_0000, 8'h00, 8'h00);
    run(4'h1, 1'b1, 1'b1, 24'hFF_FFFF, 8'h00, 8'hA5);
    run(4'h1, 1'b1, 1'b0, 24'hFF_FFFF, 8'h00, 8'h00);
    power_control_reg_i = 8'h10;
    run(4'h3, 1'b0, 1'b0, 24'h00_0000, 8'h00, 8'h00);
    power_control_reg_i = 8'h00;
    clock_divider_control_i = 3'h1;
    run(4'h2, 1'b1, 1'b1, 24'h12_3456, 8'h02, 8'h3C);
    run(4'h2, 1'b1, 1'b0, 24'h12_3456, 8'h02, 8'h00);
    clock_divider_control_i = 3'h0;
    repeat (6) begin
      port_latch_i = 8'($random(seed));
      repeat (3) @(posedge ref_clk_i);
      #1 check("idle oe", ~port_latch_i, low_byte_port_oe_o);
    end
    repeat (40) begin
      n = $random(seed);
      run(4'(n), n[4], n[5], 24'($random(seed)), 8'(n[8:6] % 3'h6), 8'(n >> 12));
    end
    results();
  end
endmodule : external_data_bus_ale_tb
`default_nettype wire
